// ### slsi_device.sv
// device end: lin, spi slave, wake, pwm gating, reset pin
`timescale 1ns/1ps

// Function
// - rxd low on dominant bus, high recessive
// - txd low drives dominant, high recessive
// - undriven txd reads recessive via pull-up
// - transceiver active only in normal modes
// - flag txd dominant for the timeout
// - low-power wake needs deglitched dominant
// - stop-mode bus wake pulls irq low
// - mosi captured on sclk rising edge
// - miso updated on sclk falling edge
// - miso released while chip select high
// - host holds chip select low per frame
// - eight bits, byte latched on cs rise
// - cs rise in stop makes wake
// - pwm drives high side only normal modes
// - host enables pwm via high side register
// - host pwm no faster than 10 kHz
// - reset pin two-way, active low
// - filtered reset release enters normal request
// - reset lows under deglitch time ignored
// - irq clears only after status read
module slsi_device
    import slsi_pkg::*;
#(
    parameter int DOM_CYCLES = TXDDOM_CYCLES,
    parameter int WIDTH = SPI_BITS
)
(
    input wire logic clk,
    input wire logic reset,
    slsi_link_if.device link,
    input wire logic linLevel,
    input slsi_mode_type mode,
    input wire logic [WIDTH-1:0] txByte,
    input wire logic hsPwmEnable,
    input wire logic statusAck,
    input wire logic hostResetReq,
    output logic linDominant,
    output logic highSideSwitch,
    output logic [WIDTH-1:0] rxByte,
    output logic rxValid,
    input wire logic rxReady,
    output logic frameError,
    output logic rxOverrun,
    output logic txdFault,
    output logic busWake,
    output logic csWake,
    output logic hostResetSeen,
    output logic enterNormalRequest
);
    logic [SYNC_WIDTH-1:0] syncA_reg;
    logic [SYNC_WIDTH-1:0] syncB_reg;
    logic sclkPrev_reg;
    logic csPrev_reg;
    logic [WIDTH-1:0] shiftIn_reg;
    logic [WIDTH-1:0] shiftOut_reg;
    logic [3:0] bitCount_reg;
    logic [WIDTH-1:0] push_reg;
    logic pushValid_reg;
    logic bufReady;
    logic [31:0] domCount_reg;
    logic [11:0] wakeCount_reg;
    logic [5:0] rstCount_reg;
    logic irqPending_reg;
    logic irqPending_next;
    logic stopIrqEvent;
    logic faultPrev_reg;
    logic active;
    logic lowPower;
    logic sclkRise;
    logic sclkFall;
    logic csFall;
    logic csRise;
    logic txdS;
    logic linS;
    logic rstS;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // two flops per pin; only stage two is read
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            syncA_reg <= SYNC_IDLE;
            syncB_reg <= SYNC_IDLE;
            sclkPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
        end
        else
        begin
            syncA_reg <= {linLevel, link.rstN, link.pwmCtl, link.csN, link.mosi, link.sclk, link.txd};
            syncB_reg <= syncA_reg;
            sclkPrev_reg <= syncB_reg[SYNC_SCLK];
            csPrev_reg <= syncB_reg[SYNC_CSN];
        end
    end

    assign txdS = syncB_reg[SYNC_TXD];
    assign linS = syncB_reg[SYNC_LIN];
    assign rstS = syncB_reg[SYNC_RSTN];
    assign sclkRise = syncB_reg[SYNC_SCLK] & ~sclkPrev_reg;
    assign sclkFall = ~syncB_reg[SYNC_SCLK] & sclkPrev_reg;
    assign csFall = ~syncB_reg[SYNC_CSN] & csPrev_reg;
    assign csRise = syncB_reg[SYNC_CSN] & ~csPrev_reg;
    assign active = (mode == SLSI_MODE_NORMAL) || (mode == SLSI_MODE_NORMAL_REQ);
    assign lowPower = (mode == SLSI_MODE_STOP) || (mode == SLSI_MODE_SLEEP);

    // ------------------------------------------------------------------
    // lin transceiver and permanent-dominant guard
    // ------------------------------------------------------------------
    // txd high restarts the count and lifts the fault
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            domCount_reg <= '0;
            txdFault <= 1'b0;
        end
        else if (txdS)
        begin
            domCount_reg <= '0;
            txdFault <= 1'b0;
        end
        else if (domCount_reg >= 32'(DOM_CYCLES - 1))
        begin
            txdFault <= 1'b1;
        end
        else
        begin
            domCount_reg <= domCount_reg + 32'd1;
        end
    end

    // bus drive and receive gated by mode
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            linDominant <= 1'b0;
            link.rxd <= 1'b1;
        end
        else
        begin
            linDominant <= active & ~txdS & ~txdFault;
            link.rxd <= active ? linS : 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // bus wake deglitch in stop and sleep
    // ------------------------------------------------------------------
    // one wake per dominant phase; the count parks
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wakeCount_reg <= '0;
            busWake <= 1'b0;
        end
        else
        begin
            busWake <= 1'b0;
            if (~lowPower | linS)
            begin
                wakeCount_reg <= '0;
            end
            else if (wakeCount_reg < 12'(WAKE_DEGLITCH_CYCLES))
            begin
                wakeCount_reg <= wakeCount_reg + 12'd1;
                busWake <= (wakeCount_reg == 12'(WAKE_DEGLITCH_CYCLES - 1));
            end
        end
    end

    assign stopIrqEvent = (mode == SLSI_MODE_STOP) && (wakeCount_reg == 12'(STOP_IRQ_CYCLES - 1));

    // ------------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------------
    // a new event beats a same-cycle acknowledge
    always_comb
    begin
        irqPending_next = irqPending_reg;
        if (statusAck)
        begin
            irqPending_next = 1'b0;
        end
        if (stopIrqEvent | (txdFault & ~faultPrev_reg))
        begin
            irqPending_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irqPending_reg <= 1'b0;
            faultPrev_reg <= 1'b0;
            link.irqN <= 1'b1;
        end
        else
        begin
            irqPending_reg <= irqPending_next;
            faultPrev_reg <= txdFault;
            link.irqN <= ~irqPending_next;
        end
    end

    // ------------------------------------------------------------------
    // spi slave
    // ------------------------------------------------------------------
    // saturating count rejects over-long frames
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            shiftIn_reg <= '0;
            shiftOut_reg <= '0;
            bitCount_reg <= '0;
            link.misoO <= 1'b0;
            link.misoOe <= 1'b0;
        end
        else
        begin
            link.misoOe <= ~syncB_reg[SYNC_CSN];
            if (csFall)
            begin
                bitCount_reg <= '0;
                shiftOut_reg <= txByte;
                link.misoO <= txByte[WIDTH-1];
            end
            else if (~syncB_reg[SYNC_CSN] & sclkRise)
            begin
                shiftIn_reg <= {shiftIn_reg[WIDTH-2:0], syncB_reg[SYNC_MOSI]};
                if (bitCount_reg != 4'hf)
                begin
                    bitCount_reg <= bitCount_reg + 4'h1;
                end
            end
            else if (~syncB_reg[SYNC_CSN] & sclkFall)
            begin
                shiftOut_reg <= {shiftOut_reg[WIDTH-2:0], 1'b0};
                link.misoO <= shiftOut_reg[WIDTH-2];
            end
        end
    end

    // frame end: latch byte, or flag bad length or overrun
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            push_reg <= '0;
            pushValid_reg <= 1'b0;
            frameError <= 1'b0;
            rxOverrun <= 1'b0;
            csWake <= 1'b0;
        end
        else
        begin
            pushValid_reg <= 1'b0;
            frameError <= 1'b0;
            rxOverrun <= 1'b0;
            csWake <= csRise & (mode == SLSI_MODE_STOP);
            if (csRise)
            begin
                if (bitCount_reg != 4'(WIDTH))
                begin
                    frameError <= 1'b1;
                end
                else if (bufReady & ~pushValid_reg)
                begin
                    push_reg <= shiftIn_reg;
                    pushValid_reg <= 1'b1;
                end
                else
                begin
                    rxOverrun <= 1'b1;
                end
            end
        end
    end

    // a stalled reader keeps two bytes, then overrun
    slsi_skid_buf #(.WIDTH(WIDTH)) rxBuffer
    (
        .clk(clk),
        .reset(reset),
        .inData(push_reg),
        .inValid(pushValid_reg),
        .inReady(bufReady),
        .outData(rxByte),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    // ------------------------------------------------------------------
    // high side pwm gating
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            highSideSwitch <= 1'b0;
        end
        else
        begin
            highSideSwitch <= active & hsPwmEnable & syncB_reg[SYNC_PWM];
        end
    end

    // ------------------------------------------------------------------
    // reset pin: drive, deglitch, release
    // ------------------------------------------------------------------
    // own pull-down also counts as a report
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            link.devRstDrive <= 1'b0;
            rstCount_reg <= '0;
            hostResetSeen <= 1'b0;
            enterNormalRequest <= 1'b0;
        end
        else
        begin
            link.devRstDrive <= hostResetReq;
            enterNormalRequest <= 1'b0;
            if (rstS)
            begin
                rstCount_reg <= '0;
                hostResetSeen <= 1'b0;
                enterNormalRequest <= hostResetSeen;
            end
            else if (rstCount_reg < 6'(RST_DEGLITCH_CYCLES))
            begin
                rstCount_reg <= rstCount_reg + 6'd1;
            end
            else
            begin
                hostResetSeen <= 1'b1;
            end
        end
    end
endmodule : slsi_device

// ### slsi_pkg.sv
// constants and types for the lin/spi mcu interface
package slsi_pkg;

    // ----------------
    // clock and timing
    // ----------------
    localparam int CLK_MHZ = 50;
    localparam int TXDDOM_MS = 1000;                                  // permanent_dominant_timeout, nominal
    localparam int TXDDOM_CYCLES = TXDDOM_MS * 1000 * CLK_MHZ;
    localparam int WAKE_DEGLITCH_US = 70;                             // bus_wake_deglitch_time, nominal
    localparam int WAKE_DEGLITCH_CYCLES = WAKE_DEGLITCH_US * CLK_MHZ;
    localparam int STOP_IRQ_US = 13;                                  // stop wake to irq, nominal
    localparam int STOP_IRQ_CYCLES = STOP_IRQ_US * CLK_MHZ;
    localparam int RST_DEGLITCH_NS = 600;
    localparam int RST_DEGLITCH_CYCLES = (RST_DEGLITCH_NS * CLK_MHZ) / 1000;
    localparam int SCLK_HALF_CYCLES = 4;                              // host divider, 160 ns link period
    localparam int SPI_BITS = 8;

    // ----------------
    // synchroniser layout on the device side
    // ----------------
    localparam int SYNC_TXD = 0;
    localparam int SYNC_SCLK = 1;
    localparam int SYNC_MOSI = 2;
    localparam int SYNC_CSN = 3;
    localparam int SYNC_PWM = 4;
    localparam int SYNC_RSTN = 5;
    localparam int SYNC_LIN = 6;
    localparam int SYNC_WIDTH = 7;
    localparam logic [6:0] SYNC_IDLE = 7'h69;                         // lin, rstN, csN, txd idle high

    // host side: miso, rxd, irqN, rstN
    localparam int HSYNC_WIDTH = 4;
    localparam logic [3:0] HSYNC_IDLE = 4'hf;                         // all four idle high, reset pin included

    // operating mode from the mode controller
    typedef enum logic [2:0]
    {
        SLSI_MODE_RESET,
        SLSI_MODE_NORMAL_REQ,
        SLSI_MODE_NORMAL,
        SLSI_MODE_STOP,
        SLSI_MODE_SLEEP
    } slsi_mode_type;

endpackage : slsi_pkg

// ### slsi_link_if.sv
// pin-level link between the host microcontroller and the device
`timescale 1ns/1ps
interface slsi_link_if;
    logic txdO;
    logic txdOe;
    logic sclk;
    logic mosi;
    logic csN;
    logic pwmCtl;
    logic hostRstDrive;
    logic misoO;
    logic misoOe;
    logic rxd;
    logic irqN;
    logic devRstDrive;
    logic txd;
    logic miso;
    logic rstN;

    // ------------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------------
    // released txd idles recessive via pull-up
    assign txd = txdOe ? txdO : 1'b1;
    // undriven miso reads high here
    assign miso = misoOe ? misoO : 1'b1;
    // open-drain reset: either end pulls it low
    assign rstN = ~(hostRstDrive | devRstDrive);

    modport device
    (
        input txd,
        input sclk,
        input mosi,
        input csN,
        input pwmCtl,
        input rstN,
        output misoO,
        output misoOe,
        output rxd,
        output irqN,
        output devRstDrive
    );

    modport host
    (
        output txdO,
        output txdOe,
        output sclk,
        output mosi,
        output csN,
        output pwmCtl,
        output hostRstDrive,
        input miso,
        input rxd,
        input irqN,
        input rstN
    );
endinterface : slsi_link_if

// ### slsi_skid_buf.sv
// two-entry buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/1ps
module slsi_skid_buf
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    logic [WIDTH-1:0] tail_reg;
    logic tailValid_reg;
    logic push;
    logic pop;

    // ready is "tail free", independent of outReady
    assign inReady = ~tailValid_reg;
    assign push = inValid & ~tailValid_reg;
    assign pop = outValid & outReady;

    // ------------------------------------------------------------------
    // head and tail slots
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            outData <= '0;
            outValid <= 1'b0;
            tail_reg <= '0;
            tailValid_reg <= 1'b0;
        end
        else if (~outValid | pop)
        begin
            if (tailValid_reg)
            begin
                outData <= tail_reg;
                outValid <= 1'b1;
                tailValid_reg <= 1'b0;
            end
            else
            begin
                outData <= inData;
                outValid <= push;
            end
        end
        else if (push)
        begin
            tail_reg <= inData;
            tailValid_reg <= 1'b1;
        end
    end
endmodule : slsi_skid_buf

// ### slsi_host.sv
// host end: spi master with divided clock, txd, pwm and reset drive
`timescale 1ns/1ps
module slsi_host
    import slsi_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYCLES,
    parameter int WIDTH = SPI_BITS
)
(
    input wire logic clk,
    input wire logic reset,
    slsi_link_if.host link,
    input wire logic start,
    input wire logic [WIDTH-1:0] txByte,
    input wire logic txdLevel,
    input wire logic txdFloat,
    input wire logic pwmLevel,
    input wire logic resetDevice,
    output logic busy,
    output logic done,
    output logic [WIDTH-1:0] rxByte,
    output logic rxdSeen,
    output logic irqSeenN,
    output logic rstSeenN
);
    typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, LAG, GAP} slsi_state_type;

    slsi_state_type state_reg;
    logic [HSYNC_WIDTH-1:0] syncA_reg;
    logic [HSYNC_WIDTH-1:0] syncB_reg;
    logic [7:0] div_reg;
    logic [3:0] bits_reg;
    logic [WIDTH-1:0] shiftOut_reg;
    logic [WIDTH-1:0] shiftIn_reg;
    logic halfDone;

    assign halfDone = (div_reg == 8'(HALF - 1));

    // ------------------------------------------------------------------
    // synchronisers and plain pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            syncA_reg <= HSYNC_IDLE;
            syncB_reg <= HSYNC_IDLE;
            link.txdO <= 1'b1;
            link.txdOe <= 1'b0;
            link.pwmCtl <= 1'b0;
            link.hostRstDrive <= 1'b0;
        end
        else
        begin
            syncA_reg <= {link.miso, link.rxd, link.irqN, link.rstN};
            syncB_reg <= syncA_reg;
            link.txdO <= txdLevel;
            link.txdOe <= ~txdFloat;
            link.pwmCtl <= pwmLevel;
            link.hostRstDrive <= resetDevice;
        end
    end

    assign rxdSeen = syncB_reg[2];
    assign irqSeenN = syncB_reg[1];
    assign rstSeenN = syncB_reg[0];

    // ------------------------------------------------------------------
    // spi master, mode 0, sclk from a divider
    // ------------------------------------------------------------------
    // miso sampled late in high phase, after both sync delays
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= IDLE;
            div_reg <= '0;
            bits_reg <= '0;
            shiftOut_reg <= '0;
            shiftIn_reg <= '0;
            rxByte <= '0;
            done <= 1'b0;
            busy <= 1'b0;
            link.csN <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            div_reg <= halfDone ? 8'd0 : div_reg + 8'd1;
            case (state_reg)
                IDLE:
                begin
                    div_reg <= '0;
                    if (start)
                    begin
                        busy <= 1'b1;
                        link.csN <= 1'b0;
                        link.mosi <= txByte[WIDTH-1];
                        shiftOut_reg <= {txByte[WIDTH-2:0], 1'b0};
                        bits_reg <= '0;
                        state_reg <= LEAD;
                    end
                end
                LEAD, LOW:
                begin
                    if (halfDone)
                    begin
                        link.sclk <= 1'b1;
                        state_reg <= HIGH;
                    end
                end
                HIGH:
                begin
                    if (halfDone)
                    begin
                        shiftIn_reg <= {shiftIn_reg[WIDTH-2:0], syncB_reg[3]};
                        link.sclk <= 1'b0;
                        bits_reg <= bits_reg + 4'd1;
                        link.mosi <= shiftOut_reg[WIDTH-1];
                        shiftOut_reg <= {shiftOut_reg[WIDTH-2:0], 1'b0};
                        state_reg <= (bits_reg == 4'(WIDTH - 1)) ? LAG : LOW;
                    end
                end
                LAG:
                begin
                    if (halfDone)
                    begin
                        link.csN <= 1'b1;
                        rxByte <= shiftIn_reg;
                        done <= 1'b1;
                        state_reg <= GAP;
                    end
                end
                GAP:
                begin
                    if (halfDone)
                    begin
                        busy <= 1'b0;
                        state_reg <= IDLE;
                    end
                end
                default:
                begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end
endmodule : slsi_host

// ### slsi_link_chk.sv
// assertions on the host-device pin link
`timescale 1ns/1ps
module slsi_link_chk
(
    input wire logic clk,
    input wire logic reset,
    input wire logic txd,
    input wire logic txdOe,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic csN,
    input wire logic misoO,
    input wire logic misoOe,
    input wire logic rstN,
    input wire logic hostRstDrive,
    input wire logic devRstDrive
);
    // ----
    // frame bookkeeping
    // ----
    logic [3:0] bitCnt_reg;
    logic sclk_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // sclk rises per frame, cleared while deselected
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bitCnt_reg <= 4'h0;
            sclk_reg <= 1'h0;
        end
        else
        begin
            sclk_reg <= sclk;
            if (csN)
                bitCnt_reg <= 4'h0;
            else if (sclk && !sclk_reg)
                bitCnt_reg <= bitCnt_reg + 4'h1;
        end
    end

    sequence frameEnd;
        $rose(csN);
    endsequence
    sequence csSelect;
        $fell(csN);
    endsequence

    bitCount_a: assert property (frameEnd |-> bitCnt_reg == 4'h8)
        else $error("frame without eight clocks");
    misoOn_a: assert property (csSelect |-> ##[1:5] misoOe)
        else $error("miso not driven after select");
    misoOff_a: assert property (csN [*5] |-> !misoOe)
        else $error("miso driven while deselected");
    misoShift_a: assert property ($changed(misoO) && $past(misoOe) |-> !$past(sclk, 3))
        else $error("miso moved away from falling clock");
    mosiHold_a: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("mosi moved at sampling edge");
    csFrame_a: assert property (sclk |-> !csN)
        else $error("clock pulse outside select");
    txdPull_a: assert property (!txdOe |-> txd)
        else $error("released txd not recessive");
    rstWire_a: assert property ((hostRstDrive || devRstDrive) |-> !rstN)
        else $error("reset pin not low while pulled");
endmodule : slsi_link_chk

// ### tb_top.sv
// testbench: host and device joined by the link
`timescale 1ns/1ps
module tb_top
    import slsi_pkg::*;
;
    logic clk = 1'h0, reset = 1'h1, linLevel = 1'h1, hsPwmEnable = 1'h0, statusAck = 1'h0, hostResetReq = 1'h0;
    logic rxReady = 1'h0, start = 1'h0, txdLevel = 1'h1, txdFloat = 1'h1, pwmLevel = 1'h0, resetDevice = 1'h0;
    logic [7:0] devTx = 8'h00, hostTx = 8'h00, devRx, hostRx;
    logic linDominant, highSide, rxValid, rxOverrun, txdFault, busWake, csWake, hostResetSeen, enterNormalRequest;
    logic done, rxdSeen, irqSeenN, rstSeenN;
    slsi_mode_type mode = SLSI_MODE_NORMAL;
    int fail_count = 0, checks_done = 0, ovrCnt = 0, wakeCnt = 0, csWakeCnt = 0, nrCnt = 0, cycles = 0, k, i;
    // row: host byte, device byte
    logic [15:0] rows [4] = '{16'ha53c, 16'h00ff, 16'hff00, 16'h817e};

    slsi_link_if linkIf ();
    // short fault timeout
    slsi_device #(.DOM_CYCLES(200)) slsi_device_i (.clk, .reset, .link(linkIf), .linLevel, .mode,
        .txByte(devTx), .hsPwmEnable, .statusAck, .hostResetReq, .linDominant, .highSideSwitch(highSide),
        .rxByte(devRx), .rxValid, .rxReady, .frameError(), .rxOverrun, .txdFault, .busWake, .csWake,
        .hostResetSeen, .enterNormalRequest);
    slsi_host slsi_host_i (.clk, .reset, .link(linkIf), .start, .txByte(hostTx), .txdLevel, .txdFloat,
        .pwmLevel, .resetDevice, .busy(), .done, .rxByte(hostRx), .rxdSeen, .irqSeenN, .rstSeenN);
    slsi_link_chk slsi_link_chk_i (.clk, .reset, .txd(linkIf.txd), .txdOe(linkIf.txdOe), .sclk(linkIf.sclk),
        .mosi(linkIf.mosi), .csN(linkIf.csN), .misoO(linkIf.misoO), .misoOe(linkIf.misoOe), .rstN(linkIf.rstN),
        .hostRstDrive(linkIf.hostRstDrive), .devRstDrive(linkIf.devRstDrive));

    // 50 MHz clock
    always #10 clk = ~clk;

    // pulse tallies and hang guard
    always @(posedge clk)
    begin
        ovrCnt <= ovrCnt + int'(rxOverrun);
        wakeCnt <= wakeCnt + int'(busWake);
        csWakeCnt <= csWakeCnt + int'(csWake);
        nrCnt <= nrCnt + int'(enterNormalRequest);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic spi(input logic [7:0] h, input logic [7:0] d);
        hostTx = h;
        devTx = d;
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        for (i = 0; i < 200 && done !== 1'h1; i++)
            @(negedge clk);
        chk("hostRx", hostRx, d);
        repeat (10) @(negedge clk);
    endtask : spi

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // inputs move on falling edges
    initial
    begin
        repeat (5) @(negedge clk);
        reset = 1'h0;
        chk("rxValid", rxValid, 8'h00);
        // stalled reader: two bytes kept, rest dropped
        for (k = 0; k < 4; k++)
            spi(rows[k][15:8], rows[k][7:0]);
        chk("overrun", ovrCnt[7:0], 8'h02);
        rxReady = 1'h1;
        for (k = 0; k < 2; k++)
        begin
            for (i = 0; i < 20 && rxValid !== 1'h1; i++)
                @(negedge clk);
            chk("devRx", devRx, rows[k][15:8]);
            @(negedge clk);
        end
        txdFloat = 1'h0;
        txdLevel = 1'h0;
        repeat (5) @(negedge clk);
        chk("linDom", linDominant, 8'h01);
        txdFloat = 1'h1;
        linLevel = 1'h0;
        repeat (8) @(negedge clk);
        chk("linRel", linDominant, 8'h00);
        chk("rxd", rxdSeen, 8'h00);
        linLevel = 1'h1;
        mode = SLSI_MODE_STOP;
        txdFloat = 1'h0;
        repeat (8) @(negedge clk);
        chk("stopDom", linDominant, 8'h00);
        txdFloat = 1'h1;
        linLevel = 1'h0;
        repeat (8) @(negedge clk);
        chk("stopRxd", rxdSeen, 8'h01);
        // short dip below both counts
        repeat (592) @(negedge clk);
        linLevel = 1'h1;
        repeat (10) @(negedge clk);
        chk("shortIrq", irqSeenN, 8'h01);
        chk("shortWake", wakeCnt[7:0], 8'h00);
        linLevel = 1'h0;
        repeat (700) @(negedge clk);
        chk("stopIrq", irqSeenN, 8'h00);
        chk("earlyWake", wakeCnt[7:0], 8'h00);
        repeat (2900) @(negedge clk);
        chk("wake", wakeCnt[7:0], 8'h01);
        linLevel = 1'h1;
        statusAck = 1'h1;
        @(negedge clk);
        statusAck = 1'h0;
        repeat (6) @(negedge clk);
        chk("irqClr", irqSeenN, 8'h01);
        spi(8'h11, 8'h22);
        chk("csWake", csWakeCnt[7:0], 8'h01);
        mode = SLSI_MODE_NORMAL;
        txdFloat = 1'h0;
        repeat (150) @(negedge clk);
        chk("noFault", txdFault, 8'h00);
        repeat (100) @(negedge clk);
        chk("fault", txdFault, 8'h01);
        chk("faultRel", linDominant, 8'h00);
        chk("faultIrq", irqSeenN, 8'h00);
        txdLevel = 1'h1;
        repeat (5) @(negedge clk);
        chk("faultClr", txdFault, 8'h00);
        hsPwmEnable = 1'h1;
        pwmLevel = 1'h1;
        repeat (5) @(negedge clk);
        chk("hsOn", highSide, 8'h01);
        mode = SLSI_MODE_SLEEP;
        repeat (3) @(negedge clk);
        chk("hsOff", highSide, 8'h00);
        // reset glitch filtered, long low reported
        mode = SLSI_MODE_NORMAL;
        resetDevice = 1'h1;
        repeat (10) @(negedge clk);
        resetDevice = 1'h0;
        repeat (10) @(negedge clk);
        chk("rstGlitch", nrCnt[7:0], 8'h00);
        resetDevice = 1'h1;
        repeat (50) @(negedge clk);
        chk("rstSeen", hostResetSeen, 8'h01);
        resetDevice = 1'h0;
        repeat (10) @(negedge clk);
        chk("normReq", nrCnt[7:0], 8'h01);
        hostResetReq = 1'h1;
        repeat (6) @(negedge clk);
        chk("devRst", rstSeenN, 8'h00);
        hostResetReq = 1'h0;
        repeat (50) @(negedge clk);
        summarize();
    end
endmodule : tb_top
